// ==== pbd_core.sv ====
// Prefix decode, illegal code reset and flag update for an 8-bit core
//
// Summary of operation
// - Instructions span one to four bytes.
// - Prefix precedes opcode, then up to two operands.
// - Prefix 90 swaps X for Y.
// - Prefix 92 selects indirect addressing forms.
// - Prefix 91 makes indirect indexed use Y.
// - Undefined code triggers reset.
// - Valid prefix plus valid opcode never resets.
// - Multiply: X high, A low, clear H,C.
// - Clear carry only.
// - Set carry only.
// - Unmask interrupts clears I.
// - Mask interrupts sets I.
// - Logical right shift zeroes N and MSB.
// - Arithmetic right shift keeps bit 7.
// - Left shifts insert zero, MSB to carry.
// - Nibble swap updates N,Z, not C.
// - Subtract with borrow: A-M-C into A.
// - Stack pointer reset loads top of stack.
// - Trap sets I, enters interrupt always.
// - Wait clears I, halts until interrupt.
// - Load copies value, updates N and Z.
`timescale 1ns/1ps
`default_nettype none
module pbd_core #(
  parameter int OPERAND_MAX = pbd_pkg::MAX_OPERANDS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Byte stream from program memory, already decoded by the opcode table
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_op_defined,
  input wire logic [4:0] i_op_code,
  input wire logic [1:0] i_op_operands,
  input wire logic [7:0] i_mem_operand,
  input wire logic i_dst_y,
  // Interrupt request
  input wire logic i_irq,
  // Results
  output logic o_byte_ready,
  output logic o_illegal_reset,
  output logic o_interrupt_entry,
  output logic o_insn_done,
  output logic [2:0] o_insn_len,
  output pbd_pkg::pbd_mode_type o_mode,
  output pbd_pkg::pbd_regs_type o_regs,
  output logic [7:0] o_result,
  output logic [7:0] o_cond_code,
  output logic [7:0] o_stack_ptr,
  output logic o_waiting
);
  // The operand counter is two bits wide, so no other operand limit can be served
  if (OPERAND_MAX != pbd_pkg::MAX_OPERANDS) begin : g_bad_operand_max
    $error("OPERAND_MAX must be 2");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  pbd_pkg::pbd_state_type state_reg, state_next;
  logic pfx_seen_reg;
  logic [1:0] opnd_left_reg;
  logic [2:0] len_reg;
  pbd_pkg::pbd_mode_type mode_reg;
  pbd_pkg::pbd_regs_type regs_reg;
  logic [7:0] condition_code_reg, sp_reg, result_reg;
  logic waiting_reg;
  logic [4:0] pend_op_reg;
  logic illegal_reg, trap_reg, done_reg, ready_reg;

  // ----------------------------------------
  // Byte classification
  // ----------------------------------------
  wire take = i_byte_valid && ready_reg;
  wire is_pfx_y = (i_byte == pbd_pkg::PFX_USE_Y);
  wire is_pfx_iy = (i_byte == pbd_pkg::PFX_IND_Y);
  wire is_pfx_ix = (i_byte == pbd_pkg::PFX_IND_X);
  wire is_pfx = (is_pfx_y || is_pfx_iy || is_pfx_ix) && !pfx_seen_reg;
  wire op_ok = i_op_defined && (i_op_code <= pbd_pkg::OP_LAST);
  // A second prefix is not an opcode, so it counts as undefined.
  wire bad_code = !is_pfx && !op_ok;
  wire fetch_take = take && (state_reg == pbd_pkg::ST_FETCH);
  wire opcode_take = fetch_take && !is_pfx && op_ok;
  wire last_opnd = (opnd_left_reg == 2'h1);
  wire exec_now = (opcode_take && (i_op_operands == pbd_pkg::LEN_W0))
    || (take && state_reg == pbd_pkg::ST_OPER && last_opnd);
  wire [4:0] exec_op = (state_reg == pbd_pkg::ST_FETCH) ? i_op_code : pend_op_reg;

  // ----------------------------------------
  // Execute datapath
  // ----------------------------------------
  wire [7:0] src = i_mem_operand;
  wire cin = condition_code_reg[pbd_pkg::FLG_C];
  wire [15:0] product = regs_reg.x * regs_reg.a;
  wire [8:0] diff = {1'b0, regs_reg.a} - {1'b0, src} - {8'h00, cin};
  logic [7:0] res;
  logic [7:0] condition_code_next;
  logic upd_nz, wr_a;
  always_comb begin
    res = src;
    condition_code_next = condition_code_reg;
    upd_nz = 1'b0;
    wr_a = 1'b0;
    case (exec_op)
      pbd_pkg::OP_LOAD: begin
        res = src;
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_MULTIPLY: begin
        condition_code_next[pbd_pkg::FLG_H] = 1'b0;
        condition_code_next[pbd_pkg::FLG_C] = 1'b0;
      end
      pbd_pkg::OP_CLEAR_CARRY: condition_code_next[pbd_pkg::FLG_C] = 1'b0;
      pbd_pkg::OP_SET_CARRY: condition_code_next[pbd_pkg::FLG_C] = 1'b1;
      pbd_pkg::OP_UNMASK: condition_code_next[pbd_pkg::FLG_I] = 1'b0;
      pbd_pkg::OP_MASK: condition_code_next[pbd_pkg::FLG_I] = 1'b1;
      pbd_pkg::OP_SHR_LOGIC: begin
        res = {1'b0, src[7:1]};
        condition_code_next[pbd_pkg::FLG_C] = src[0];
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_SHR_ARITH: begin
        res = {src[7], src[7:1]};
        condition_code_next[pbd_pkg::FLG_C] = src[0];
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_SHL_LOGIC, pbd_pkg::OP_SHL_ARITH: begin
        res = {src[6:0], 1'b0};
        condition_code_next[pbd_pkg::FLG_C] = src[7];
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_ROL_CARRY: begin
        res = {src[6:0], cin};
        condition_code_next[pbd_pkg::FLG_C] = src[7];
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_ROR_CARRY: begin
        res = {cin, src[7:1]};
        condition_code_next[pbd_pkg::FLG_C] = src[0];
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_SWAP: begin
        res = {src[3:0], src[7:4]};
        upd_nz = 1'b1;
      end
      pbd_pkg::OP_SUB_BORROW: begin
        res = diff[7:0];
        condition_code_next[pbd_pkg::FLG_C] = diff[8];
        upd_nz = 1'b1;
        wr_a = 1'b1;
      end
      pbd_pkg::OP_TRAP: condition_code_next[pbd_pkg::FLG_I] = 1'b1;
      pbd_pkg::OP_WAIT_IRQ: condition_code_next[pbd_pkg::FLG_I] = 1'b0;
      default: condition_code_next = condition_code_reg;
    endcase
    if (upd_nz) begin
      condition_code_next[pbd_pkg::FLG_N] = res[7];
      condition_code_next[pbd_pkg::FLG_Z] = (res == 8'h00);
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pbd_pkg::ST_FETCH: begin
        if (opcode_take && i_op_operands != pbd_pkg::LEN_W0) begin
          state_next = pbd_pkg::ST_OPER;
        end else if (opcode_take && i_op_code == pbd_pkg::OP_WAIT_IRQ) begin
          state_next = pbd_pkg::ST_WAIT;
        end
      end
      pbd_pkg::ST_OPER: begin
        if (take && last_opnd) begin
          state_next = (pend_op_reg == pbd_pkg::OP_WAIT_IRQ) ? pbd_pkg::ST_WAIT : pbd_pkg::ST_FETCH;
        end
      end
      pbd_pkg::ST_WAIT: begin
        if (i_irq) begin
          state_next = pbd_pkg::ST_FETCH;
        end
      end
      default: state_next = pbd_pkg::ST_FETCH;
    endcase
  end

  wire [2:0] len_next = len_reg + 3'h1;

  always_ff @(posedge i_clock) begin
    if (i_srst || illegal_reg) begin
      state_reg <= pbd_pkg::ST_FETCH;
      pfx_seen_reg <= 1'b0;
      opnd_left_reg <= 2'h0;
      len_reg <= 3'h0;
      mode_reg <= '0;
      regs_reg <= '0;
      condition_code_reg <= pbd_pkg::FLAGS_RESET;
      waiting_reg <= 1'b0;
      sp_reg <= pbd_pkg::SP_TOP;
      result_reg <= 8'h00;
      pend_op_reg <= pbd_pkg::OP_NOP;
      illegal_reg <= 1'b0;
      trap_reg <= 1'b0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      waiting_reg <= (state_next == pbd_pkg::ST_WAIT);
      illegal_reg <= fetch_take && bad_code;
      done_reg <= exec_now;
      trap_reg <= exec_now && exec_op == pbd_pkg::OP_TRAP;
      ready_reg <= (state_next != pbd_pkg::ST_WAIT) && !(fetch_take && bad_code);
      if (fetch_take && is_pfx) begin
        pfx_seen_reg <= 1'b1;
        len_reg <= 3'h1;
        mode_reg.use_y <= is_pfx_y || is_pfx_iy;
        mode_reg.indirect <= is_pfx_ix || is_pfx_iy;
      end else if (opcode_take) begin
        pfx_seen_reg <= 1'b0;
        len_reg <= pfx_seen_reg ? 3'h2 : 3'h1;
        if (!pfx_seen_reg) begin
          mode_reg <= '0;
        end
        opnd_left_reg <= i_op_operands;
        pend_op_reg <= i_op_code;
      end else if (take && state_reg == pbd_pkg::ST_OPER) begin
        opnd_left_reg <= opnd_left_reg - 2'h1;
        len_reg <= len_next;
      end
      if (exec_now) begin
        condition_code_reg <= condition_code_next;
        result_reg <= res;
        if (exec_op == pbd_pkg::OP_MULTIPLY) begin
          regs_reg.x <= product[15:8];
          regs_reg.a <= product[7:0];
        end else if (wr_a) begin
          regs_reg.a <= res;
        end else if (exec_op == pbd_pkg::OP_LOAD) begin
          if (mode_reg.use_y || i_dst_y) begin
            regs_reg.y <= res;
          end else begin
            regs_reg.a <= res;
          end
        end
        if (exec_op == pbd_pkg::OP_SP_RESET) begin
          sp_reg <= pbd_pkg::SP_TOP;
        end
      end
    end
  end

  assign o_byte_ready = ready_reg;
  assign o_illegal_reset = illegal_reg;
  assign o_interrupt_entry = trap_reg;
  assign o_insn_done = done_reg;
  assign o_insn_len = len_reg;
  assign o_mode = mode_reg;
  assign o_regs = regs_reg;
  assign o_result = result_reg;
  assign o_cond_code = condition_code_reg;
  assign o_stack_ptr = sp_reg;
  assign o_waiting = waiting_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_bad_fetch;
    fetch_take && bad_code;
  endsequence
  sequence s_exec(logic [4:0] op);
    exec_now && exec_op == op;
  endsequence
  a_len_bound: assert property (@(posedge i_clock) disable iff (i_srst) o_insn_len <= 3'(pbd_pkg::MAX_LEN))
    else $error("instruction length above four");
  a_illegal_reset: assert property (@(posedge i_clock) disable iff (i_srst) s_bad_fetch |=> o_illegal_reset)
    else $error("undefined code did not reset");
  a_prefix_legal: assert property (@(posedge i_clock) disable iff (i_srst)
    (fetch_take && pfx_seen_reg && op_ok) |=> !o_illegal_reset)
    else $error("prefixed valid opcode reset");
  a_prefix_y: assert property (@(posedge i_clock) disable iff (i_srst)
    (fetch_take && is_pfx_y && !pfx_seen_reg) |=> (o_mode.use_y && !o_mode.indirect))
    else $error("y prefix mode wrong");
  a_prefix_ix: assert property (@(posedge i_clock) disable iff (i_srst)
    (fetch_take && is_pfx_ix && !pfx_seen_reg) |=> (!o_mode.use_y && o_mode.indirect))
    else $error("indirect prefix mode wrong");
  a_multiply_flags: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_MULTIPLY) |=> (!o_cond_code[pbd_pkg::FLG_C] && !o_cond_code[pbd_pkg::FLG_H]))
    else $error("multiply flags wrong");
  a_multiply_result: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_MULTIPLY) |=> {o_regs.x, o_regs.a} == $past(regs_reg.x) * $past(regs_reg.a))
    else $error("multiply result wrong");
  a_set_carry_only: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_SET_CARRY) |=> o_cond_code == ($past(condition_code_reg) | 8'h01))
    else $error("set carry touched other flags");
  a_clear_carry_only: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_CLEAR_CARRY) |=> o_cond_code == ($past(condition_code_reg) & 8'hFE))
    else $error("clear carry touched other flags");
  a_unmask_irq: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_UNMASK) |=> !o_cond_code[pbd_pkg::FLG_I])
    else $error("unmask left mask set");
  a_mask_irq: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_MASK) |=> o_cond_code[pbd_pkg::FLG_I])
    else $error("mask left mask clear");
  a_shr_logic_sign: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_SHR_LOGIC) |=> !o_cond_code[pbd_pkg::FLG_N] && !o_result[7])
    else $error("logical right shift sign wrong");
  a_shr_arith_keep: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_SHR_ARITH) |=> o_result[7] == $past(i_mem_operand[7])
    && o_cond_code[pbd_pkg::FLG_C] == $past(i_mem_operand[0]))
    else $error("arithmetic right shift wrong");
  a_shl_zero_in: assert property (@(posedge i_clock) disable iff (i_srst)
    (exec_now && (exec_op == pbd_pkg::OP_SHL_LOGIC || exec_op == pbd_pkg::OP_SHL_ARITH))
    |=> !o_result[0] && o_cond_code[pbd_pkg::FLG_C] == $past(i_mem_operand[7]))
    else $error("left shift wrong");
  a_swap_keep_c: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_SWAP) |=> o_cond_code[pbd_pkg::FLG_C] == $past(condition_code_reg[pbd_pkg::FLG_C])
    && o_result == {$past(i_mem_operand[3:0]), $past(i_mem_operand[7:4])})
    else $error("nibble swap wrong");
  a_load_flags: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_LOAD) |=> o_result == $past(i_mem_operand) && o_cond_code[pbd_pkg::FLG_N] == o_result[7]
    && o_cond_code[pbd_pkg::FLG_Z] == (o_result == 8'h00))
    else $error("load flags wrong");
  a_wait_enter: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_WAIT_IRQ) |=> o_waiting && !o_cond_code[pbd_pkg::FLG_I])
    else $error("wait did not unmask and halt");
  a_wait_hold: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_waiting && !i_irq) |=> o_waiting && !o_byte_ready)
    else $error("wait left without interrupt");
  a_trap_mask: assert property (@(posedge i_clock) disable iff (i_srst)
    (exec_now && exec_op == pbd_pkg::OP_TRAP) |=> (o_interrupt_entry && o_cond_code[pbd_pkg::FLG_I]))
    else $error("trap did not mask");
  a_sp_reset_top: assert property (@(posedge i_clock) disable iff (i_srst)
    s_exec(pbd_pkg::OP_SP_RESET) |=> o_stack_ptr == pbd_pkg::SP_TOP)
    else $error("stack pointer not at top");
endmodule // pbd_core
`default_nettype wire

// ==== pbd_pkg.sv ====
// Package for the prefix decode and flag update block
package pbd_pkg;
  // ----------------------------------------
  // Prefix bytes and opcodes
  // ----------------------------------------
  localparam logic [7:0] PFX_USE_Y = 8'h90;
  localparam logic [7:0] PFX_IND_Y = 8'h91;
  localparam logic [7:0] PFX_IND_X = 8'h92;
  localparam int MAX_LEN = 4;
  localparam int MAX_OPERANDS = 2;
  localparam logic [1:0] LEN_W0 = 2'h0;
  // Internal operation codes presented on i_op_code
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_LOAD = 5'h01;
  localparam logic [4:0] OP_MULTIPLY = 5'h02;
  localparam logic [4:0] OP_CLEAR_CARRY = 5'h03;
  localparam logic [4:0] OP_SET_CARRY = 5'h04;
  localparam logic [4:0] OP_UNMASK = 5'h05;
  localparam logic [4:0] OP_MASK = 5'h06;
  localparam logic [4:0] OP_SHR_LOGIC = 5'h07;
  localparam logic [4:0] OP_SHR_ARITH = 5'h08;
  localparam logic [4:0] OP_SHL_LOGIC = 5'h09;
  localparam logic [4:0] OP_SHL_ARITH = 5'h0A;
  localparam logic [4:0] OP_ROL_CARRY = 5'h0B;
  localparam logic [4:0] OP_ROR_CARRY = 5'h0C;
  localparam logic [4:0] OP_SWAP = 5'h0D;
  localparam logic [4:0] OP_SUB_BORROW = 5'h0E;
  localparam logic [4:0] OP_SP_RESET = 5'h0F;
  localparam logic [4:0] OP_TRAP = 5'h10;
  localparam logic [4:0] OP_WAIT_IRQ = 5'h11;
  localparam logic [4:0] OP_LAST = 5'h11;
  localparam logic [7:0] SP_TOP = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'h08;
  // Flag positions in the condition code byte
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;

  typedef enum logic [2:0] {
    ST_FETCH = 3'h1,
    ST_OPER = 3'h2,
    ST_WAIT = 3'h4
  } pbd_state_type;

  typedef struct packed {
    logic use_y;
    logic indirect;
  } pbd_mode_type;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
  } pbd_regs_type;
endpackage

// ==== pbd_pmem.sv ====
// Program memory model that streams instruction bytes with their opcode table entry
`timescale 1ns/1ps
`default_nettype none
module pbd_pmem (
  // Clock, reset and start of a program
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_go,
  input wire logic [3:0] i_count,
  // Byte stream towards the core
  input wire logic i_ready,
  output logic o_valid,
  output logic [15:0] o_entry
);
  logic [15:0] mem [0:15];
  logic [3:0] ptr_reg;
  logic [7:0] last_reg;
  assign o_valid = !i_go && (ptr_reg < i_count);
  // Released bus shows the inverted last byte so a stale copy is never taken for data
  assign o_entry = o_valid ? mem[ptr_reg] : {~last_reg, 8'h00};
  always_ff @(posedge i_clock) begin
    if (i_srst || i_go) begin
      ptr_reg <= 4'h0;
      last_reg <= 8'h00;
    end else if (o_valid && i_ready) begin
      ptr_reg <= ptr_reg + 4'h1;
      last_reg <= o_entry[15:8];
    end
  end
endmodule // pbd_pmem
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the prefix decode and flag update core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] OPR = {8'hAA, 1'b1, 5'h00, 2'h0};
  logic clk = 1'b0, srst = 1'b1, go = 1'b0, dsty = 1'b0, irq = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] opnd = 8'h00, flags_exp = pbd_pkg::FLAGS_RESET, res, flags, sp;
  logic pv, rdy, ill, trp, done, wt;
  logic [15:0] ent;
  logic [2:0] len, len_cap;
  pbd_pkg::pbd_mode_type mode, mode_cap;
  pbd_pkg::pbd_regs_type regs;
  int fail_count = 0, comparisons = 0, cycles = 0, ill_n = 0, trp_n = 0;
  pbd_core dut (.i_clock(clk), .i_srst(srst), .i_byte_valid(pv), .i_byte(ent[15:8]), .i_op_defined(ent[7]),
    .i_op_code(ent[6:2]), .i_op_operands(ent[1:0]), .i_mem_operand(opnd), .i_dst_y(dsty), .i_irq(irq),
    .o_byte_ready(rdy), .o_illegal_reset(ill), .o_interrupt_entry(trp), .o_insn_done(done), .o_insn_len(len),
    .o_mode(mode), .o_regs(regs), .o_result(res), .o_cond_code(flags), .o_stack_ptr(sp), .o_waiting(wt));
  pbd_pmem pm (.i_clock(clk), .i_srst(srst), .i_go(go), .i_count(cnt), .i_ready(rdy), .o_valid(pv),
    .o_entry(ent));
  always #12.5 clk = ~clk;
  // Pulses are only one cycle wide, so they are counted here rather than polled
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (ill) ill_n <= ill_n + 1;
    if (trp) trp_n <= trp_n + 1;
    if (len == 3'h1) mode_cap <= mode;
    if (done) len_cap <= len;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] opc(input logic [4:0] op, input logic [1:0] n);
    return {8'h01, 1'b1, op, n};
  endfunction
  // Entries are given first byte leftmost; the model streams them back to back
  task automatic run(input logic [63:0] p, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) pm.mem[i] = p[16*(n-1-i) +: 16];
    ill_n = 0;
    trp_n = 0;
    go <= 1'b1;
    cnt <= 4'(n);
    @(posedge clk) go <= 1'b0;
    for (int k = 0; k < 60 && (go || pv); k++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_flags();
    check(flags, pbd_pkg::FLAGS_RESET);
    check(sp, pbd_pkg::SP_TOP);
    for (int i = 0; i < 4; i++) begin
      run(opc((i == 0) ? pbd_pkg::OP_SET_CARRY : (i == 1) ? pbd_pkg::OP_MASK : (i == 2) ? pbd_pkg::OP_CLEAR_CARRY :
        pbd_pkg::OP_UNMASK, 2'h0), 1);
      flags_exp[(i % 2) ? pbd_pkg::FLG_I : pbd_pkg::FLG_C] = (i < 2);
      check(flags, flags_exp);
    end
  endtask
  task automatic t_load_arith();
    logic [7:0] ld [3] = '{8'h80, 8'h7F, 8'h00};
    for (int i = 0; i < 3; i++) begin
      dsty <= (i == 1);
      opnd <= ld[i];
      run(opc(pbd_pkg::OP_LOAD, 2'h0), 1);
      flags_exp[2:1] = {ld[i][7], ld[i] == 8'h00};
      check(flags, flags_exp);
    end
    check(regs, {8'h00, 8'h00, 8'h7F});
    dsty <= 1'b0;
    opnd <= 8'h10;
    run({opc(pbd_pkg::OP_LOAD, 2'h0), opc(pbd_pkg::OP_SET_CARRY, 2'h0), opc(pbd_pkg::OP_SUB_BORROW, 2'h0)}, 3);
    check(regs.a, 8'hFF);
    flags_exp[2:0] = 3'h5;
    check(flags, flags_exp);
    run({opc(pbd_pkg::OP_SET_CARRY, 2'h0), opc(pbd_pkg::OP_MULTIPLY, 2'h0)}, 2);
    check(regs, {8'h00, 8'h00, 8'h7F});
    flags_exp[pbd_pkg::FLG_C] = 1'b0;
    flags_exp[pbd_pkg::FLG_H] = 1'b0;
    check(flags, flags_exp);
  endtask
  function automatic logic [8:0] shf(input logic [4:0] op, input logic [7:0] s, input logic c);
    case (op)
      pbd_pkg::OP_SHR_LOGIC: return {s[0], 1'b0, s[7:1]};
      pbd_pkg::OP_SHR_ARITH: return {s[0], s[7], s[7:1]};
      pbd_pkg::OP_SHL_LOGIC, pbd_pkg::OP_SHL_ARITH: return {s[7], s[6:0], 1'b0};
      pbd_pkg::OP_ROL_CARRY: return {s[7], s[6:0], c};
      pbd_pkg::OP_ROR_CARRY: return {s[0], c, s[7:1]};
      default: return {c, s[3:0], s[7:4]};
    endcase
  endfunction
  task automatic t_shift();
    logic [4:0] sh [7] = '{pbd_pkg::OP_SHR_LOGIC, pbd_pkg::OP_SHR_ARITH, pbd_pkg::OP_SHL_LOGIC, pbd_pkg::OP_SHL_ARITH,
      pbd_pkg::OP_ROL_CARRY, pbd_pkg::OP_ROR_CARRY, pbd_pkg::OP_SWAP};
    logic [7:0] sv [3] = '{8'h81, 8'h40, 8'h00};
    logic [8:0] r;
    for (int k = 0; k < 42; k++) begin
      opnd <= sv[k % 3];
      run({opc((k % 2) ? pbd_pkg::OP_SET_CARRY : pbd_pkg::OP_CLEAR_CARRY, 2'h0), opc(sh[k / 6], 2'h0)}, 2);
      r = shf(sh[k / 6], sv[k % 3], k % 2);
      check(res, r[7:0]);
      flags_exp[2:0] = {r[7], r[7:0] == 8'h00, r[8]};
      check(flags, flags_exp);
    end
  endtask
  task automatic t_prefix();
    logic [7:0] pf [3] = '{pbd_pkg::PFX_USE_Y, pbd_pkg::PFX_IND_Y, pbd_pkg::PFX_IND_X};
    logic [1:0] md [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    for (int i = 0; i < 4; i++) begin
      if (i < 3) run({pf[i], 8'h00, opc(pbd_pkg::OP_LOAD, 2'h2), OPR, OPR}, 4);
      else run({opc(pbd_pkg::OP_LOAD, 2'h2), OPR, OPR}, 3);
      check(mode_cap, md[i]);
      check(len_cap, (i < 3) ? 4 : 3);
      check(ill_n, 0);
    end
  endtask
  task automatic t_trap_wait();
    for (int i = 0; i < 2; i++) begin
      run({opc(i ? pbd_pkg::OP_MASK : pbd_pkg::OP_UNMASK, 2'h0), opc(pbd_pkg::OP_TRAP, 2'h0)}, 2);
      check(trp_n, 1);
      check(flags[pbd_pkg::FLG_I], 1'b1);
    end
    run(opc(pbd_pkg::OP_SP_RESET, 2'h0), 1);
    check(sp, pbd_pkg::SP_TOP);
    run({opc(pbd_pkg::OP_MASK, 2'h0), opc(pbd_pkg::OP_WAIT_IRQ, 2'h0)}, 2);
    check({wt, rdy, flags[pbd_pkg::FLG_I]}, 3'h4);
    irq <= 1'b1;
    for (int k = 0; k < 10 && wt === 1'b1; k++) @(posedge clk);
    #1;
    check(wt, 1'b0);
    irq <= 1'b0;
  endtask
  task automatic t_illegal();
    logic [63:0] bad [4] = '{{8'h01, 8'h00}, {pbd_pkg::PFX_USE_Y, 8'h00, pbd_pkg::PFX_IND_Y, 8'h00},
      {pbd_pkg::PFX_IND_X, 8'h00, 8'h01, 8'h00}, {pbd_pkg::PFX_IND_X, 8'h00, opc(pbd_pkg::OP_SWAP, 2'h0)}};
    for (int i = 0; i < 4; i++) begin
      run(bad[i], (i == 0) ? 1 : 2);
      check(ill_n, (i < 3) ? 1 : 0);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_flags();
    t_load_arith();
    t_shift();
    t_prefix();
    t_trap_wait();
    t_illegal();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
